// *** logic/shared_bus_pkg.sv ***
// Purpose: constants shared by both ends of the shared address/data bus
// Assumes: single clock, synchronous active-high reset
// Notes:   device end and host end meet in shared_bus_if
//
// What this block does
// R1 - select low: line n carries data bit n
// R2 - 8-bit mode: host holds line 8 low
// R3 - 16-bit address: line 8 is address bit 8
// R4 - 8-bit: lines 7..3 address first, ignored second
// R5 - 16-bit address: lines 7..2 address in one cycle
// R6 - 8-bit: line 2 is bit 2, then 10
// R7 - 8-bit: line 1 is bit 1, then 9
// R8 - 16-bit address: device ignores line 1
// R9 - data uses 16 lines, or low 8 lines
// R10 - 16-bit address: lines 15..12 byte enables, 11 ignored
// R11 - 8-bit: bits 7..0, then 10..8 on 2..0
// R12 - device toggles phase per 8-bit address write
package shared_bus_pkg;

  localparam int BUS_W   = 16;
  localparam int ADDR_W  = 11;
  localparam int BE_W    = 4;
  localparam int BE_LSB  = 12;
  localparam int LOW_W   = 8;
  localparam int HI_W    = 3;

  localparam logic [BUS_W-1:0]  BUS_RST  = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [BE_W-1:0]   BE_RST   = 4'h0;

  typedef enum logic {PHASE_FIRST, PHASE_SECOND} addr_phase_e;

endpackage

// *** logic/shared_bus_if.sv ***
// Purpose: wire bundle between host end and device end
// Assumes: testbench resolves the shared wire from both enables
// Notes:   select and strobes are driven by the host only
interface shared_bus_if;
  import shared_bus_pkg::*;

  logic [BUS_W-1:0] host_bus_out;
  logic             host_bus_oe;
  logic [BUS_W-1:0] dev_bus_out;
  logic             dev_bus_oe;
  logic [BUS_W-1:0] bus_in;
  logic             addr_data_select;
  logic             wr_strobe;
  logic             rd_strobe;
  logic             mode_16bit;

  modport device (
    input  bus_in,
    input  addr_data_select,
    input  wr_strobe,
    input  rd_strobe,
    input  mode_16bit,
    output dev_bus_out,
    output dev_bus_oe
  );

  modport host (
    input  bus_in,
    output host_bus_out,
    output host_bus_oe,
    output addr_data_select,
    output wr_strobe,
    output rd_strobe,
    output mode_16bit
  );

endinterface

// *** logic/shared_bus_device.sv ***
// Purpose: device end, demultiplexes address and data off the shared lines
// Assumes: bus inputs synchronous to i_clk, strobes one cycle wide
// Notes:   read data is presented while rd_strobe is high
module shared_bus_device
  import shared_bus_pkg::*;
(
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_sys_rst,
  input  wire logic                         i_clk_en,
  // link
  shared_bus_if.device                      bus,
  // user side
  input  wire logic [shared_bus_pkg::BUS_W-1:0]  i_rd_data,
  output logic      [shared_bus_pkg::ADDR_W-1:0] o_addr,
  output logic      [shared_bus_pkg::BE_W-1:0]   o_byte_lane_enables,
  output logic                              o_addr_valid,
  output logic      [shared_bus_pkg::BUS_W-1:0]  o_wr_data,
  output logic                              o_wr_valid,
  output logic                              o_rd_req,
  output logic                              o_phase_second
);
  import shared_bus_pkg::*;

  addr_phase_e phase;
  logic        addr_wr;
  logic        data_wr;

  assign addr_wr = bus.wr_strobe & bus.addr_data_select;
  assign data_wr = bus.wr_strobe & ~bus.addr_data_select;

  // --------------------------------------------------------------
  // address phase
  // --------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      phase <= PHASE_FIRST;
    else if (i_clk_en && addr_wr && !bus.mode_16bit)
      phase <= (phase == PHASE_FIRST) ? PHASE_SECOND : PHASE_FIRST; // R12
    else if (i_clk_en && bus.mode_16bit)
      phase <= PHASE_FIRST;
  end

  assign o_phase_second = (phase == PHASE_SECOND);

  // --------------------------------------------------------------
  // address capture
  // --------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_addr              <= ADDR_RST;
      o_byte_lane_enables <= BE_RST;
      o_addr_valid        <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_addr_valid <= 1'b0;
      if (addr_wr && bus.mode_16bit)
      begin
        o_addr[10:2]        <= bus.bus_in[10:2]; // R3 R5
        o_addr[1:0]         <= 2'h0; // R8
        o_byte_lane_enables <= bus.bus_in[BE_LSB +: BE_W]; // R10
        o_addr_valid        <= 1'b1;
      end
      else if (addr_wr && phase == PHASE_FIRST)
      begin
        o_addr[7:0] <= bus.bus_in[7:0]; // R4 R6 R7 R11
      end
      else if (addr_wr)
      begin
        o_addr[10:8]        <= bus.bus_in[2:0]; // R6 R7 R11
        o_byte_lane_enables <= BE_RST;
        o_addr_valid        <= 1'b1; // R4
      end
    end
  end

  // --------------------------------------------------------------
  // data path
  // --------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_wr_data  <= BUS_RST;
      o_wr_valid <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_wr_valid <= data_wr;
      if (data_wr)
        o_wr_data <= bus.mode_16bit ? bus.bus_in
                     : {8'h00, bus.bus_in[LOW_W-1:0]}; // R1 R2 R9
    end
  end

  assign o_rd_req = bus.rd_strobe & ~bus.addr_data_select;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      bus.dev_bus_out <= BUS_RST;
    else if (i_clk_en)
      bus.dev_bus_out <= bus.mode_16bit ? i_rd_data
                         : {8'h00, i_rd_data[LOW_W-1:0]}; // R1 R9
  end

  assign bus.dev_bus_oe = o_rd_req;

endmodule

// *** logic/shared_bus_host.sv ***
// Purpose: host end, drives address, data and, in 16-bit mode only, byte enables on the shared lines
// Assumes: one request per command pulse, o_busy low before next request
// Notes:   an 8-bit address takes two write cycles
module shared_bus_host
  import shared_bus_pkg::*;
(
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_sys_rst,
  input  wire logic                         i_clk_en,
  // link
  shared_bus_if.host                        bus,
  // user side
  input  wire logic                         i_mode_16bit,
  input  wire logic                         i_start,
  input  wire logic                         i_write,
  input  wire logic [shared_bus_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [shared_bus_pkg::BE_W-1:0]   i_byte_lane_enables,
  input  wire logic [shared_bus_pkg::BUS_W-1:0]  i_wr_data,
  output logic      [shared_bus_pkg::BUS_W-1:0]  o_rd_data,
  output logic                              o_rd_valid,
  output logic                              o_busy
);
  import shared_bus_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ADDR_HI, S_DATA} host_state_e;

  host_state_e               state;
  logic                      wr_op;
  logic [ADDR_W-1:0]         addr;
  logic [BE_W-1:0]           be;
  logic [BUS_W-1:0]          wdata;
  logic [BUS_W-1:0]          next_out;
  logic                      next_sel;
  logic                      next_wr;
  logic                      next_rd;

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state <= S_IDLE;
      wr_op <= 1'b0;
      addr  <= ADDR_RST;
      be    <= BE_RST;
      wdata <= BUS_RST;
    end
    else if (i_clk_en)
    begin
      case (state)
        S_IDLE:
          if (i_start)
          begin
            wr_op <= i_write;
            addr  <= i_addr;
            be    <= i_byte_lane_enables;
            wdata <= i_wr_data;
            state <= i_mode_16bit ? S_DATA : S_ADDR_HI;
          end
        S_ADDR_HI:
          state <= S_DATA;
        S_DATA:
          state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // line drive
  // --------------------------------------------------------------
  always_comb
  begin
    next_out = BUS_RST;
    next_sel = 1'b0;
    next_wr  = 1'b0;
    next_rd  = 1'b0;
    case (state)
      S_IDLE:
        if (i_start)
        begin
          next_sel = 1'b1;
          next_wr  = 1'b1;
          if (i_mode_16bit)
            next_out = {i_byte_lane_enables, 1'b0, i_addr[10:2], 2'h0}; // R3 R5 R8 R10
          else
            next_out = {8'h00, i_addr[7:0]}; // R2 R11
        end
      S_ADDR_HI:
      begin
        next_sel = 1'b1;
        next_wr  = 1'b1;
        next_out = {13'h0, addr[10:8]}; // R4 R6 R7 R11
      end
      S_DATA:
      begin
        next_wr  = wr_op;
        next_rd  = ~wr_op;
        if (wr_op)
          next_out = i_mode_16bit ? wdata : {8'h00, wdata[LOW_W-1:0]}; // R1 R2 R9
      end
      default:
        next_out = BUS_RST;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      bus.host_bus_out     <= BUS_RST;
      bus.host_bus_oe      <= 1'b0;
      bus.addr_data_select <= 1'b0;
      bus.wr_strobe        <= 1'b0;
      bus.rd_strobe        <= 1'b0;
    end
    else if (i_clk_en)
    begin
      bus.host_bus_out     <= next_out;
      bus.host_bus_oe      <= next_wr;
      bus.addr_data_select <= next_sel;
      bus.wr_strobe        <= next_wr;
      bus.rd_strobe        <= next_rd;
    end
  end

  assign bus.mode_16bit = i_mode_16bit;

  // --------------------------------------------------------------
  // read return
  // --------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_rd_data  <= BUS_RST;
      o_rd_valid <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_rd_valid <= bus.rd_strobe;
      if (bus.rd_strobe)
        o_rd_data <= i_mode_16bit ? bus.bus_in : {8'h00, bus.bus_in[LOW_W-1:0]}; // R9
    end
  end

  assign o_busy = (state != S_IDLE) | bus.wr_strobe | bus.rd_strobe;

endmodule

// *** tb/shared_bus_monitor.sv ***
// Purpose: wire checks between host end and device end
// Assumes: one clock, sync active-high reset
// Notes:   sees shared_bus_if signals only
module shared_bus_monitor
  import shared_bus_pkg::*;
(
  // clock and reset
  input  wire logic                             i_clk,
  input  wire logic                             i_sys_rst,
  // link
  input  wire logic [shared_bus_pkg::BUS_W-1:0] host_bus_out,
  input  wire logic                             host_bus_oe,
  input  wire logic                             dev_bus_oe,
  input  wire logic                             addr_data_select,
  input  wire logic                             wr_strobe,
  input  wire logic                             rd_strobe,
  input  wire logic                             mode_16bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence addr_wr;
    addr_data_select && wr_strobe;
  endsequence
  sequence data_cyc;
    !addr_data_select && (wr_strobe || rd_strobe);
  endsequence
  chk_dev_drives_read: assert property (dev_bus_oe == (rd_strobe && !addr_data_select))
    else $error("device drive enable wrong");
  chk_addr_host_only: assert property (addr_data_select |-> host_bus_oe && !dev_bus_oe)
    else $error("address cycle not driven by host alone");
  chk_line8_ground: assert property (!mode_16bit && host_bus_oe |-> !host_bus_out[8])
    else $error("line 8 not low in 8-bit mode");
  chk_upper_ground: assert property (!mode_16bit && host_bus_oe |-> host_bus_out[15:9] == 7'h00)
    else $error("upper lines not low in 8-bit mode");
  chk_two_addr_writes: assert property ((!mode_16bit && !$past(addr_data_select)) ##0 addr_wr |=> addr_wr)
    else $error("second address write missing");
  chk_then_data: assert property (!mode_16bit ##0 addr_wr ##1 addr_wr |=> data_cyc)
    else $error("no data cycle after address pair");
  chk_single_addr: assert property (mode_16bit ##0 addr_wr |=> data_cyc)
    else $error("16-bit address took more than one cycle");
  chk_one_strobe: assert property (!(wr_strobe && rd_strobe))
    else $error("both strobes high");
  chk_no_contention: assert property (!(host_bus_oe && dev_bus_oe))
    else $error("both ends drive the lines");
endmodule

// *** tb/shared_bus_addr_data_demux_tb.sv ***
// Purpose: host end against device end, plus a rule-breaking host
// Assumes: 200 MHz clock, reset held 12 cycles
// Notes:   second link drives a device end directly
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: mismatch", $time); end end
module shared_bus_addr_data_demux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import shared_bus_pkg::*;
  typedef struct packed {
    logic m16; logic wr; logic [10:0] addr; logic [3:0] be; logic [15:0] data;
    logic [10:0] x_addr; logic [3:0] x_be; logic [15:0] x_data;
  } row_s;
  row_s rows [6] = '{
    '{1'b1, 1'b1, 11'h7FF, 4'hA, 16'hA5C3, 11'h7FC, 4'hA, 16'hA5C3},
    '{1'b1, 1'b0, 11'h107, 4'h5, 16'h3C96, 11'h104, 4'h5, 16'h3C96},
    '{1'b0, 1'b1, 11'h6B5, 4'hF, 16'hFF81, 11'h6B5, 4'h0, 16'h0081},
    '{1'b0, 1'b0, 11'h34A, 4'h0, 16'h00E7, 11'h34A, 4'h0, 16'h00E7},
    '{1'b0, 1'b1, 11'h0FF, 4'h0, 16'h5A5A, 11'h0FF, 4'h0, 16'h005A},
    '{1'b1, 1'b1, 11'h003, 4'h1, 16'h0001, 11'h000, 4'h1, 16'h0001}};
  logic        i_clk, i_sys_rst, mode, start, write, o_addr_valid, o_wr_valid, o_phase_second;
  logic        h_rd_valid, h_busy, b_addr_valid, b_wr_valid, b_phase, rd_req, bad_en;
  logic [10:0] addr, o_addr, b_addr;
  logic [3:0]  be, o_byte_lane_enables;
  logic [15:0] wdata, rdata, o_wr_data, h_rd_data, b_wr_data;
  int          error_cnt = 0, samples_checked = 0, cycles = 0;
  shared_bus_if link();
  shared_bus_if bad();
  assign link.bus_in = link.dev_bus_oe ? link.dev_bus_out
                     : link.host_bus_oe ? link.host_bus_out : 16'h0000;
  shared_bus_device i_shared_bus_device (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .bus(link.device), .i_rd_data(rdata), .o_addr(o_addr),
    .o_byte_lane_enables(o_byte_lane_enables), .o_addr_valid(o_addr_valid),
    .o_wr_data(o_wr_data), .o_wr_valid(o_wr_valid), .o_rd_req(rd_req),
    .o_phase_second(o_phase_second));
  shared_bus_host i_shared_bus_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .bus(link.host), .i_mode_16bit(mode), .i_start(start), .i_write(write), .i_addr(addr),
    .i_byte_lane_enables(be), .i_wr_data(wdata), .o_rd_data(h_rd_data),
    .o_rd_valid(h_rd_valid), .o_busy(h_busy));
  shared_bus_device i_shared_bus_device_bad (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_clk_en(bad_en), .bus(bad.device), .i_rd_data(16'h0000), .o_addr(b_addr),
    .o_byte_lane_enables(), .o_addr_valid(b_addr_valid), .o_wr_data(b_wr_data),
    .o_wr_valid(b_wr_valid), .o_rd_req(), .o_phase_second(b_phase));
  shared_bus_monitor i_shared_bus_monitor (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .host_bus_out(link.host_bus_out), .host_bus_oe(link.host_bus_oe),
    .dev_bus_oe(link.dev_bus_oe), .addr_data_select(link.addr_data_select),
    .wr_strobe(link.wr_strobe), .rd_strobe(link.rd_strobe), .mode_16bit(link.mode_16bit));
  task automatic test_done;
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xfer(input row_s r);
    int n;
    mode = r.m16; write = r.wr; addr = r.addr; be = r.be; wdata = r.data; rdata = r.data;
    start = 1'b1;
    @(posedge i_clk); #1 start = 1'b0;
    n = 0;
    while (o_addr_valid !== 1'b1 && n < 8)
    begin
      @(posedge i_clk); #1 n++;
    end
    `CHK(o_addr_valid, 1'b1)
    `CHK(o_addr, r.x_addr)
    `CHK(o_byte_lane_enables, r.x_be)
    `CHK(rd_req, ~r.wr)
    while (o_wr_valid !== 1'b1 && h_rd_valid !== 1'b1 && n < 16)
    begin
      @(posedge i_clk); #1 n++;
    end
    `CHK(r.wr ? o_wr_valid : h_rd_valid, 1'b1)
    if (r.wr) `CHK(o_wr_data, r.x_data)
    else `CHK(h_rd_data, r.x_data)
    while (h_busy !== 1'b0 && n < 24)
    begin
      @(posedge i_clk); #1 n++;
    end
    `CHK(h_busy, 1'b0)
  endtask
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    i_sys_rst = 1'b1; mode = 1'b1; start = 1'b0; write = 1'b0;
    addr = 11'h000; be = 4'h0; wdata = 16'h0000; rdata = 16'h0000;
    bad.bus_in = 16'h0000; bad.addr_data_select = 1'b0; bad.wr_strobe = 1'b0;
    bad.rd_strobe = 1'b0; bad.mode_16bit = 1'b0; bad_en = 1'b1;
    repeat (12) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    @(posedge i_clk); #1
    `CHK({o_phase_second, o_addr_valid, o_wr_valid, h_busy, h_rd_valid}, 5'h00)
    foreach (rows[i]) xfer(rows[i]);
    `CHK(o_phase_second, 1'b0)
    // host breaking the grounding of line 8 and the upper lines
    bad_en = 1'b0;
    bad.addr_data_select = 1'b1; bad.wr_strobe = 1'b1; bad.bus_in = 16'hFF5A;
    @(posedge i_clk); #1
    `CHK({b_phase, b_addr_valid}, 2'h0)
    bad_en = 1'b1;
    @(posedge i_clk); #1
    `CHK(b_phase, 1'b1)
    bad.bus_in = 16'hFFFD;
    @(posedge i_clk); #1
    `CHK(b_addr_valid, 1'b1)
    `CHK(b_addr, 11'h55A)
    `CHK(b_phase, 1'b0)
    bad.addr_data_select = 1'b0; bad.bus_in = 16'hAB12;
    @(posedge i_clk); #1
    bad.wr_strobe = 1'b0;
    `CHK(b_wr_valid, 1'b1)
    `CHK(b_wr_data, 16'h0012)
    test_done();
  end
endmodule
